// *** autobaud_defs.vh ***
// Purpose: Register offsets, field positions, rates and response codes for the autobaud block.
// Assumes: Included by autobaud_detect.v only.
// Notes:   Offsets are byte addresses on a 32-bit AXI4-Lite bus.
`ifndef AUTOBAUD_DEFS_VH
`define AUTOBAUD_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define AB_CTRL_OFS     5'h00
`define AB_DIV_OFS      5'h04
`define AB_RXBUF_OFS    5'h08
`define AB_TXBUF_OFS    5'h0C
`define AB_STAT_OFS     5'h10
// ****************************************
// Control register fields
// ****************************************
`define AB_ENABLE_BIT   0
`define AB_WAKE_BIT     1
`define AB_HS_BIT       2
`define AB_WIDE_BIT     3
`define AB_CLKMODE_BIT  4
`define AB_OVF_BIT      7
// ****************************************
// Status register fields
// ****************************************
`define AB_RXFLAG_BIT   0
`define AB_MEASURE_BIT  1
`define AB_BREAK_BIT    2
// ****************************************
// Counter clock dividers and misc
// ****************************************
`define AB_DIV_SLOW     10'h200
`define AB_DIV_MID      10'h080
`define AB_DIV_FAST     10'h020
`define AB_EDGE_LAST    3'h5
`define AB_RESP_OKAY    2'h0
`define AB_RESP_SLVERR  2'h2
`endif

// *** autobaud_detect.v ***
// Purpose: Automatic baud-rate measurement on the receive line with AXI4-Lite registers.
// Assumes: mclk is the oscillator; rxLine is asynchronous and idles high.
// Notes:   Normal receive and transmit datapaths are outside this block.
// Summary of operation
// RL1 - Asynchronous mode when clocked-mode bit clear.
// RL2 - Measure only asynchronous with wake disabled.
// RL3 - Enable clears divider, waits start bit.
// RL4 - Divider counts, timed by receive line.
// RL5 - Remote sends 55h sync byte.
// RL6 - Count from first rising edge after start.
// RL7 - Fifth rising edge leaves divisor in bytes.
// RL8 - Enable self-clears on fifth rising edge.
// RL9 - Rollover FFFFh to 0000h sets overflow.
// RL10 - Overflow set by hardware, software writable.
// RL11 - Rollover keeps measurement and enable active.
// RL12 - Counter runs at one eighth base rate.
// RL13 - Base clock Fosc/512, /128 or /32.
// RL14 - Sixteen bit only with wide select set.
// RL15 - Receive machine held idle while measuring.
// RL16 - Receive flag set on fifth edge.
// RL17 - Reading receive buffer clears receive flag.
// RL18 - Software discards buffer value after measurement.
// RL19 - With wake, measure byte after break; the code never starts the count while wake is set, so it stays in ST_START.
// RL20 - Software should set wide select.
// RL21 - Transmit buffer refuses writes while enabled.
// RL22 - Software must not enable during transmit.
// RL23 - Divider reloads measured value afterwards.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "autobaud_defs.vh"
module autobaud_detect (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// AXI4-Lite write address
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Serial line and datapath hooks
	input  wire        rxLine,
	output reg         rxIdleHold,
	output reg         rateTick,
	output reg         rxFlag
);
	// ****************************************
	// States
	// ****************************************
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_BREAK = 2'h1;
	localparam [1:0] ST_START = 2'h2;
	localparam [1:0] ST_COUNT = 2'h3;

	reg  [1:0]  rxSync_q;
	reg         rxPrev_q;
	reg  [1:0]  state_q;
	reg  [2:0]  edgeCnt_q;
	reg  [9:0]  preCnt_q;
	reg  [2:0]  eighthCnt_q;
	reg  [15:0] divider_q;
	reg  [15:0] rateCnt_q;
	reg         enable_q;
	reg         wake_q;
	reg         highSpeed_q;
	reg         wide_q;
	reg         clkMode_q;
	reg         ovf_q;
	reg  [7:0]  txBuf_q;
	reg  [4:0]  awAddr_q;
	reg         awHave_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;
	reg         wHave_q;
	reg  [9:0]  baseDiv;
	wire        rxNow;
	wire        riseEdge;
	wire        fallEdge;
	wire        baseTick;
	wire        countTick;
	wire        measuring;
	wire        doWrite;
	wire        doRead;
	wire        ctrlWr;
	wire [15:0] countNext;

	assign rxNow     = rxSync_q[1];
	assign riseEdge  = rxNow & ~rxPrev_q;
	assign fallEdge  = ~rxNow & rxPrev_q;
	assign measuring = (state_q == ST_COUNT);
	assign doWrite   = awHave_q & wHave_q & ~s_axi_bvalid;
	assign doRead    = s_axi_arvalid & s_axi_arready;
	assign ctrlWr    = doWrite & (awAddr_q == `AB_CTRL_OFS) & wStrb_q[0];

	// ****************************************
	// Counter clock selection
	// ****************************************
	// RL13 base clock select
	always @* begin
		case ({wide_q, highSpeed_q})
			2'b00:   baseDiv = `AB_DIV_SLOW;
			2'b11:   baseDiv = `AB_DIV_FAST;
			default: baseDiv = `AB_DIV_MID;
		endcase
	end
	assign baseTick  = (preCnt_q == baseDiv - 10'h001);
	// RL12 one eighth rate
	assign countTick = baseTick & (eighthCnt_q == 3'h7);
	// RL14 eight or sixteen bit
	assign countNext = wide_q ? divider_q + 16'h0001 :
		{8'h00, divider_q[7:0] + 8'h01};

	// ****************************************
	// Synchroniser and prescaler
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			rxSync_q    <= 2'b11;
			rxPrev_q    <= 1'b1;
			preCnt_q    <= 10'h000;
			eighthCnt_q <= 3'h0;
		end else begin
			rxSync_q <= {rxSync_q[0], rxLine};
			rxPrev_q <= rxNow;
			if (baseTick) begin
				preCnt_q    <= 10'h000;
				eighthCnt_q <= eighthCnt_q + 3'h1;
			end else begin
				preCnt_q <= preCnt_q + 10'h001;
			end
		end
	end

	// ****************************************
	// Measurement state machine and registers
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			edgeCnt_q   <= 3'h0;
			divider_q   <= 16'h0000;
			rateCnt_q   <= 16'h0000;
			enable_q    <= 1'b0;
			wake_q      <= 1'b0;
			highSpeed_q <= 1'b0;
			wide_q      <= 1'b0;
			clkMode_q   <= 1'b0;
			ovf_q       <= 1'b0;
			txBuf_q     <= 8'h00;
			rxFlag      <= 1'b0;
			rxIdleHold  <= 1'b0;
			rateTick    <= 1'b0;
		end else begin
			rateTick   <= 1'b0;
			// RL15 receiver held idle
			rxIdleHold <= measuring | (state_q == ST_START);
			// RL17 read clears flag
			if (doRead && {s_axi_araddr[4:2], 2'b00} == `AB_RXBUF_OFS)
				rxFlag <= 1'b0;
			if (ctrlWr) begin
				wake_q      <= wData_q[`AB_WAKE_BIT];
				highSpeed_q <= wData_q[`AB_HS_BIT];
				wide_q      <= wData_q[`AB_WIDE_BIT];
				clkMode_q   <= wData_q[`AB_CLKMODE_BIT];
				// RL10 software writes flag
				ovf_q       <= wData_q[`AB_OVF_BIT];
				enable_q    <= wData_q[`AB_ENABLE_BIT];
				// RL3 clear divider on arm
				if (wData_q[`AB_ENABLE_BIT] && !enable_q) begin
					divider_q <= 16'h0000;
					state_q   <= wData_q[`AB_WAKE_BIT] ? ST_BREAK : ST_START;
				end
			end
			if (doWrite && awAddr_q == `AB_DIV_OFS) begin
				if (wStrb_q[0])
					divider_q[7:0] <= wData_q[7:0];
				if (wStrb_q[1])
					divider_q[15:8] <= wData_q[15:8];
			end
			// RL21 transmit lockout
			if (doWrite && awAddr_q == `AB_TXBUF_OFS && wStrb_q[0] && !enable_q)
				txBuf_q <= wData_q[7:0];
			case (state_q)
				ST_IDLE: begin
					// RL23 reload measured divisor
					if (rateCnt_q == 16'h0000) begin
						rateCnt_q <= divider_q;
						rateTick  <= 1'b1;
					end else begin
						rateCnt_q <= rateCnt_q - 16'h0001;
					end
				end
				ST_BREAK: begin
					// RL19 skip the break byte
					if (riseEdge)
						state_q <= ST_START;
				end
				ST_START: begin
					// RL1 RL2 asynchronous only
					// RL6 start on first rise
					if (riseEdge && !clkMode_q && !wake_q) begin
						state_q   <= ST_COUNT;
						edgeCnt_q <= 3'h1;
					end
				end
				ST_COUNT: begin
					// RL4 line times counter
					if (countTick) begin
						divider_q <= countNext;
						// RL9 RL11 trap rollover
						if (wide_q ? divider_q == 16'hFFFF : divider_q[7:0] == 8'hFF)
							ovf_q <= 1'b1;
					end
					if (riseEdge) begin
						edgeCnt_q <= edgeCnt_q + 3'h1;
						// RL7 RL8 RL16 finish on fifth edge
						if (edgeCnt_q == `AB_EDGE_LAST - 3'h1) begin
							state_q   <= ST_IDLE;
							enable_q  <= 1'b0;
							rxFlag    <= 1'b1;
							rateCnt_q <= 16'h0000;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			// Writing the enable low aborts a pending or running measurement.
			if (ctrlWr && !wData_q[`AB_ENABLE_BIT]) begin
				state_q <= ST_IDLE;
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// The write is taken only once both address and data are held, in either order.
	always @(posedge mclk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AB_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `AB_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			awHave_q      <= 1'b0;
			wHave_q       <= 1'b0;
			awAddr_q      <= 5'h00;
			wData_q       <= 32'h00000000;
			wStrb_q       <= 4'h0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			if (s_axi_awvalid && !awHave_q && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				awHave_q      <= 1'b1;
				awAddr_q      <= {s_axi_awaddr[4:2], 2'b00};
			end
			if (s_axi_wvalid && !wHave_q && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				wHave_q      <= 1'b1;
				wData_q      <= s_axi_wdata;
				wStrb_q      <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHave_q     <= 1'b0;
				wHave_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_q > `AB_STAT_OFS ||
					(awAddr_q == `AB_TXBUF_OFS && enable_q)) ? `AB_RESP_SLVERR : `AB_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
				s_axi_arready <= 1'b1;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AB_RESP_OKAY;
				case ({s_axi_araddr[4:2], 2'b00})
					`AB_CTRL_OFS:  s_axi_rdata <= {24'h000000, ovf_q, 2'b00, clkMode_q, wide_q,
						highSpeed_q, wake_q, enable_q};
					`AB_DIV_OFS:   s_axi_rdata <= {16'h0000, divider_q};
					`AB_RXBUF_OFS: s_axi_rdata <= 32'h00000000;
					`AB_TXBUF_OFS: s_axi_rdata <= {24'h000000, txBuf_q};
					`AB_STAT_OFS:  s_axi_rdata <= {29'h00000000, state_q == ST_BREAK,
						measuring, rxFlag};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `AB_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** autobaud_detect_monitor.sv ***
// Purpose: Port-level checks for the autobaud block.
// Assumes: One clock mclk and a synchronous active-high rst.
// Notes:   Bound to every autobaud_detect instance.
`timescale 1ns/1ps
module autobaud_detect_monitor (
	// Clock and reset
	input wire        mclk,
	input wire        rst,
	// Bus handshakes
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Measurement hooks
	input wire        rxIdleHold,
	input wire        rateTick,
	input wire        rxFlag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_read_latency: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("rvalid late");
	a_write_resp: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("bvalid late");
	a_no_tick_meas: assert property (rxIdleHold && $past(rxIdleHold) |-> !rateTick)
		else $error("sampling tick while measuring");
	a_flag_at_end: assert property ($rose(rxFlag) |-> $past(rxIdleHold))
		else $error("receive flag outside measurement");
	a_flag_clear_read: assert property ($fell(rxFlag) |->
		s_axi_rvalid || s_axi_arready || $past(s_axi_arready))
		else $error("receive flag cleared without read");
	a_tick_resume: assert property ($fell(rxIdleHold) |-> ##[1:300] rateTick)
		else $error("divider did not resume");
	c_measure_done: cover property ($rose(rxFlag));
	c_hold_end: cover property ($fell(rxIdleHold));
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind autobaud_detect autobaud_detect_monitor u_autobaud_detect_monitor (.*);

// *** sync_char_sender.sv ***
// Purpose: Remote sender of the sync character.
// Assumes: Line idles high; bit time is given in mclk cycles.
// Notes:   One frame for each send request while idle.
`timescale 1ns/1ps
module sync_char_sender (
	// Clock
	input wire        mclk,
	// Control
	input wire [15:0] bitCycles,
	input wire        send,
	// Line
	output reg        txLine = 1'h1,
	output reg        busy = 1'h0
);
	reg [9:0] frameBits;
	integer   i;
	always @(posedge mclk) begin
		if (send && !busy) begin
			frameBits = {1'h1, 8'h55, 1'h0};
			busy <= 1'h1;
			for (i = 0; i < 10; i = i + 1) begin
				txLine <= frameBits[i];
				repeat (bitCycles) @(posedge mclk);
			end
			busy <= 1'h0;
		end
	end
endmodule

// *** tb_autobaud_detect.sv ***
// Purpose: Self-checking bench for autobaud_detect.
// Assumes: One bus master and one remote sender.
// Notes:   Bit times give four counts per mode, so runs stay short.
`timescale 1ns/1ps
module tb_autobaud_detect;
	reg         mclk = 1'h0, rst = 1'h1, send = 1'h0;
	reg  [4:0]  awAddr = 5'h00, arAddr = 5'h00;
	reg  [31:0] wData = 32'h0, d;
	reg         awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
	reg  [15:0] bitCycles = 16'h0080;
	reg  [1:0]  r;
	wire        awReady, wReady, bValid, arReady, rValid, txLine, busy, rxIdleHold, rateTick, rxFlag;
	wire [1:0]  bResp, rResp;
	wire [31:0] rData;
	integer     fails = 0, checked = 0, cyc = 0, m;
	always #2 mclk = ~mclk;
	autobaud_detect u_autobaud_detect (.mclk(mclk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.rxLine(txLine), .rxIdleHold(rxIdleHold), .rateTick(rateTick), .rxFlag(rxFlag));
	sync_char_sender u_sync_char_sender (.mclk(mclk), .bitCycles(bitCycles), .send(send),
		.txLine(txLine), .busy(busy));
	task give_verdict;
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [4:0] a, input [31:0] v);
		reg ga, gw;
		begin
			ga = 1'h0;
			gw = 1'h0;
			@(posedge mclk);
			awAddr <= a;
			wData <= v;
			awValid <= 1'h1;
			wValid <= 1'h1;
			bReady <= 1'h1;
			while (!(ga && gw)) begin
				@(posedge mclk);
				if (awReady === 1'h1) awValid <= 1'h0;
				if (wReady === 1'h1) wValid <= 1'h0;
				ga = ga | (awReady === 1'h1);
				gw = gw | (wReady === 1'h1);
			end
			while (bValid !== 1'h1) @(posedge mclk);
			r = bResp;
			bReady <= 1'h0;
		end
	endtask
	task rd(input [4:0] a);
		begin
			@(posedge mclk);
			arAddr <= a;
			arValid <= 1'h1;
			rReady <= 1'h1;
			do @(posedge mclk); while (arReady !== 1'h1);
			arValid <= 1'h0;
			while (rValid !== 1'h1) @(posedge mclk);
			d = rData;
			r = rResp;
			rReady <= 1'h0;
		end
	endtask
	task frame;
		begin
			@(posedge mclk);
			send <= 1'h1;
			do @(posedge mclk); while (!busy);
			send <= 1'h0;
			do @(posedge mclk); while (busy);
		end
	endtask
	// The ceiling covers the whole run, all four modes and the later frames included, with ample margin.
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			fails = fails + 1;
			give_verdict;
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		rd(5'h10);
		chk(d, 32'h0);
		wr(5'h00, 32'h80);
		rd(5'h00);
		chk(d, 32'h80);
		rd(5'h14);
		chk(r, 2'h2);
		wr(5'h0C, 32'h3C);
		chk(r, 2'h0);
		for (m = 0; m < 4; m = m + 1) begin
			bitCycles <= (m == 0) ? 16'h0800 : (m == 3) ? 16'h0080 : 16'h0200;
			wr(5'h04, 32'hA5A5);
			wr(5'h00, {m[1:0], 2'h1});
			rd(5'h04);
			chk(d, 32'h0);
			wr(5'h0C, 32'hC3);
			chk(r, 2'h2);
			rd(5'h0C);
			chk(d, 32'h3C);
			frame;
			chk(rxFlag, 32'h1);
			rd(5'h00);
			chk(d, {m[1:0], 2'h0});
			rd(5'h04);
			// Edge phase against the prescaler may move the count by one.
			chk((d > 2 && d < 6) ? 32'h4 : d, 32'h4);
			rd(5'h08);
			@(posedge mclk);
			chk(rxFlag, 32'h0);
		end
		wr(5'h00, 32'h1D);
		frame;
		chk(rxFlag, 32'h0);
		wr(5'h00, 32'h0C);
		wr(5'h00, 32'h0F);
		rd(5'h10);
		chk(d, 32'h4);
		frame;
		chk(rxFlag, 32'h0);
		rd(5'h10);
		chk(d, 32'h0);
		// Starting near the top of the counter forces a rollover mid-byte.
		wr(5'h04, 32'hFFFE);
		wr(5'h00, 32'h0D);
		frame;
		chk(rxFlag, 32'h1);
		rd(5'h00);
		chk(d, 32'h8C);
		rd(5'h04);
		chk((d > 0 && d < 4) ? 32'h2 : d, 32'h2);
		rd(5'h08);
		wr(5'h00, 32'h0);
		give_verdict;
	end
endmodule
